/* rtl/asp_pkg.sv */
// Constants, widths and state type of the converter serial port.
package asp_pkg;

  // Clock rate of the block, which also serves as the conversion clock.
  localparam int unsigned CLK_HZ           = 50_000_000;
  // Nominal conversion time in milliseconds and the derived cycle count.
  localparam int unsigned CONV_TIME_MS     = 147;
  localparam int unsigned CONV_CYCLES_DFLT = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV_CNT_W       = 24;
  // Done-flag test window before the internal clock starts, a least time.
  localparam int unsigned EOC_TEST_US      = 23;
  localparam int unsigned EOC_TEST_CYCLES  = (EOC_TEST_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned EOC_CNT_W        = 11;
  // Internal serial clock divider and its half period.
  localparam int unsigned SCK_DIV          = 8;
  localparam int unsigned SCK_HALF         = SCK_DIV / 2;
  localparam int unsigned DIV_CNT_W        = 2;
  // Output word layout.
  localparam int unsigned WORD_BITS        = 19;
  localparam int unsigned EOC_POS          = 18;
  localparam int unsigned FILLER_POS       = 17;
  localparam int unsigned SIGN_POS         = 16;
  localparam int unsigned CODE_W           = 16;
  localparam int unsigned BIT_CNT_W        = 5;
  // Channel address shifted in from the wake-up edge through the data state.
  localparam int unsigned ADDR_BITS        = 8;
  localparam logic [7:0]  CHAN_RST         = 8'h00;
  // Clock mode after reset, before the strap is taken: internal.
  localparam logic        MODE_RST         = 1'h1;

  // Converter states.
  typedef enum logic [1:0] {
    ST_CONV,
    ST_SLEEP,
    ST_DATA
  } asp_state_t;

endpackage : asp_pkg

/* rtl/asp_sck_div.sv */
// Internal serial clock generator that divides the block clock by eight.
module asp_sck_div
  import asp_pkg::*;
(
  input  wire logic i_clk,   // Block clock.
  input  wire logic i_rst,   // Synchronous reset, active high.
  input  wire logic i_run,   // Let the serial clock toggle.
  output logic      o_sck,   // Generated serial clock level.
  output logic      o_rise,  // One-cycle pulse with each rising edge.
  output logic      o_fall   // One-cycle pulse with each falling edge.
);

  logic [DIV_CNT_W-1:0] cnt_q;  // Position inside the half period.
  logic                 sck_q;  // Clock level.
  logic                 rise_q; // Registered rising edge pulse.
  logic                 fall_q; // Registered falling edge pulse.

  // The clock idles low and the first toggle after run is a rising edge,
  // so a stopped divider always restarts with a full low half period.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      cnt_q  <= '0;
      sck_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (cnt_q == DIV_CNT_W'(SCK_HALF - 1)) begin
      cnt_q  <= '0;
      sck_q  <= ~sck_q;
      rise_q <= ~sck_q;
      fall_q <= sck_q;
    end else begin
      cnt_q  <= cnt_q + DIV_CNT_W'(1);
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
  end

  assign o_sck  = sck_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;

endmodule : asp_sck_div

/* rtl/asp_top.sv */
// Serial port of the converter: state sequence, result shifter and channel input.
module asp_top
  import asp_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DFLT // Conversion length.
)
(
  input  wire logic                 i_clk,        // Block and conversion clock.
  input  wire logic                 i_rst,        // Synchronous reset, active high.
  input  wire logic                 i_cs_n,       // Chip select, active low.
  input  wire logic                 i_sck,        // Serial clock pin level.
  input  wire logic                 i_sdi,        // Serial data input pin.
  input  wire logic                 i_sign,       // Sign of the finished result.
  input  wire logic [CODE_W-1:0]    i_code,       // Result code of the conversion.
  output logic                      o_sdo,        // Serial data output level.
  output logic                      o_sdo_oe_n,   // Output enable of sdo, low drives.
  output logic                      o_sck,        // Serial clock driven in internal mode.
  output logic                      o_sck_oe_n,   // Output enable of sck, low drives.
  output logic [ADDR_BITS-1:0]      o_channel,    // Channel for the next conversion.
  output logic                      o_conv_start, // Pulse when a conversion begins after a transfer.
  output logic                      o_converting, // High while converting.
  output logic                      o_int_mode    // High in internal clock mode.
);

  asp_state_t             st_q;         // Present converter state.
  logic [CONV_CNT_W-1:0]  conv_cnt_q;   // Cycles spent converting.
  logic [EOC_CNT_W-1:0]   eoc_cnt_q;    // Cycles of the done-flag test window.
  logic [WORD_BITS-1:0]   shift_q;      // Static output shift register.
  logic [BIT_CNT_W-1:0]   rise_cnt_q;   // Rising edges of the transfer, wake-up edge included.
  logic [ADDR_BITS-1:0]   addr_sh_q;    // Partial channel address.
  logic [ADDR_BITS-1:0]   chan_q;       // Committed channel selection.
  logic                   int_mode_q;   // Internal clock mode flag.
  logic                   por_done_q;   // Strap has been taken after reset.
  logic                   cs_prev_q;    // Chip select one cycle back.
  logic                   sck_prev_q;   // Pin clock one cycle back.
  logic                   sdo_q;        // Output data flop.
  logic                   sdo_oe_n_q;   // Output enable flop for sdo.
  logic                   sck_q;        // Output clock flop.
  logic                   sck_oe_n_q;   // Output enable flop for sck.
  logic                   start_q;      // Conversion start pulse flop.
  logic                   conv_q;       // Converting level flop.
  logic                   div_run;      // Lets the internal divider run.
  logic                   div_sck;      // Internal clock level.
  logic                   div_rise;     // Internal rising edge pulse.
  logic                   div_fall;     // Internal falling edge pulse.
  logic                   cs_fall;      // Chip select went low.
  logic                   cs_rise;      // Chip select went high.
  logic                   sck_rise;     // Serial clock rising edge, either source.
  logic                   sck_fall;     // Serial clock falling edge, either source.
  logic                   conv_done;    // Last cycle of a conversion.
  logic                   data_end;     // Last edge of a full transfer.
  logic                   go_conv;      // Leave the data state for a new conversion.

  // True when the rising edge count names a channel address bit.
  function automatic logic is_addr_bit(input logic [BIT_CNT_W-1:0] cnt);
    is_addr_bit = (cnt < BIT_CNT_W'(ADDR_BITS));
  endfunction : is_addr_bit

  // True when the rising edge count names the final address bit.
  function automatic logic is_last_addr(input logic [BIT_CNT_W-1:0] cnt);
    is_last_addr = (cnt == BIT_CNT_W'(ADDR_BITS - 1));
  endfunction : is_last_addr

  // Inputs are synchronous, so one flop of history is enough for edges.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      cs_prev_q  <= i_cs_n;
      sck_prev_q <= i_sck;
    end
  end

  assign cs_fall  = cs_prev_q && !i_cs_n;
  assign cs_rise  = !cs_prev_q && i_cs_n;
  // Pick the edge source; in internal mode the pin only echoes our own drive.
  assign sck_rise = int_mode_q ? div_rise : (i_sck && !sck_prev_q);
  assign sck_fall = int_mode_q ? div_fall : (!i_sck && sck_prev_q);

  // The internal clock runs once the test window has passed in sleep, and
  // through the data state; it stops, held high, when a conversion starts.
  assign div_run = int_mode_q && !i_cs_n &&
                   (((st_q == ST_SLEEP) && (eoc_cnt_q == EOC_CNT_W'(EOC_TEST_CYCLES))) ||
                    (st_q == ST_DATA));

  asp_sck_div u_div (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (div_run),
    .o_sck  (div_sck),
    .o_rise (div_rise),
    .o_fall (div_fall)
  );

  // Clock mode strap: taken in the first cycle after reset and again at
  // every chip-select fall. A high or floating pin means internal mode.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_mode_q <= MODE_RST;
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
      if (!por_done_q || cs_fall) begin
        int_mode_q <= i_sck;
      end
    end
  end

  assign conv_done = (st_q == ST_CONV) && (conv_cnt_q == CONV_CNT_W'(CONV_CYCLES - 1));
  // External clock ends on the nineteenth fall, internal on the nineteenth rise.
  assign data_end  = int_mode_q ?
                     (sck_rise && (rise_cnt_q == BIT_CNT_W'(WORD_BITS - 1))) :
                     (sck_fall && (rise_cnt_q == BIT_CNT_W'(WORD_BITS)));
  assign go_conv   = (st_q == ST_DATA) && (cs_rise || (!i_cs_n && data_end));

  // Converter state sequence: convert, sleep, data output and back.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= ST_CONV;
    end else begin
      unique case (st_q)
        ST_CONV: begin
          // Sleep is entered whatever chip select does.
          if (conv_done) begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // Only a rising edge while selected wakes the port.
          if (!i_cs_n && sck_rise) begin
            st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          // A deselect aborts at once; a full word also restarts.
          if (go_conv) begin
            st_q <= ST_CONV;
          end
        end
      endcase
    end
  end

  // Converting level kept in a flop of its own, so the output does not come
  // through a decode of the state. It follows the same two transitions as
  // the state register and therefore always agrees with it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      conv_q <= 1'b1;
    end else if (conv_done) begin
      conv_q <= 1'b0;
    end else if (go_conv) begin
      conv_q <= 1'b1;
    end
  end

  // Conversion length counter, cleared in every other state.
  always_ff @(posedge i_clk) begin
    if (i_rst || (st_q != ST_CONV)) begin
      conv_cnt_q <= '0;
    end else if (!conv_done) begin
      conv_cnt_q <= conv_cnt_q + CONV_CNT_W'(1);
    end
  end

  // Done-flag test window in internal mode; it saturates at its end so the
  // clock keeps running, and restarts each time the port is reselected.
  always_ff @(posedge i_clk) begin
    if (i_rst || (st_q != ST_SLEEP) || i_cs_n || !int_mode_q) begin
      eoc_cnt_q <= '0;
    end else if (eoc_cnt_q != EOC_CNT_W'(EOC_TEST_CYCLES)) begin
      eoc_cnt_q <= eoc_cnt_q + EOC_CNT_W'(1);
    end
  end

  // Result shifter: loaded as the done flag falls, shifted on falling edges.
  // The word sits still through sleep, so a deselect in sleep loses nothing.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_q <= '0;
    end else if (conv_done) begin
      shift_q             <= '0;
      shift_q[EOC_POS]    <= 1'b0;
      shift_q[FILLER_POS] <= 1'b0;
      shift_q[SIGN_POS]   <= i_sign;
      shift_q[CODE_W-1:0] <= i_code;
    end else if ((st_q == ST_DATA) && sck_fall) begin
      shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
    end
  end

  // Rising edge count of the transfer; the wake-up edge counts as the first.
  always_ff @(posedge i_clk) begin
    if (i_rst || (st_q == ST_CONV)) begin
      rise_cnt_q <= '0;
    end else if (!i_cs_n && sck_rise && (rise_cnt_q != BIT_CNT_W'(WORD_BITS))) begin
      rise_cnt_q <= rise_cnt_q + BIT_CNT_W'(1);
    end
  end

  // Channel address shifter: input sampled only while selected and out of
  // conversion, so the host may leave it at any level elsewhere.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_sh_q <= '0;
    end else if (!i_cs_n && (st_q != ST_CONV) && sck_rise && is_addr_bit(rise_cnt_q)) begin
      addr_sh_q <= {addr_sh_q[ADDR_BITS-2:0], i_sdi};
    end
  end

  // The selection changes only with its final address bit; a transfer cut
  // short before that bit leaves the old selection in place.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan_q <= CHAN_RST;
    end else if (!i_cs_n && (st_q != ST_CONV) && sck_rise && is_last_addr(rise_cnt_q)) begin
      chan_q <= {addr_sh_q[ADDR_BITS-2:0], i_sdi};
    end
  end

  // Output data: flag high while converting, low in sleep, word in data.
  // The flag keeps being driven after a transfer so its fall can interrupt.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sdo_q      <= 1'b1;
      sdo_oe_n_q <= 1'b1;
    end else begin
      sdo_oe_n_q <= i_cs_n;
      unique case (st_q)
        ST_CONV:  sdo_q <= 1'b1;
        ST_SLEEP: sdo_q <= 1'b0;
        ST_DATA:  sdo_q <= go_conv ? 1'b1 : shift_q[EOC_POS];
      endcase
    end
  end

  // Serial clock drive in internal mode: high in conversion, low in the
  // test window, divided clock in data. Released when deselected so the
  // pull-up can restore the strap level before the next selection.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sck_q      <= 1'b1;
      sck_oe_n_q <= 1'b1;
    end else begin
      sck_oe_n_q <= !(int_mode_q && !i_cs_n);
      unique case (st_q)
        ST_CONV:  sck_q <= 1'b1;
        ST_SLEEP: sck_q <= div_sck;
        ST_DATA:  sck_q <= go_conv ? 1'b1 : div_sck;
      endcase
    end
  end

  // Start pulse to the modulator; with select held low this repeats each
  // word, or each conversion in internal mode, for continuous operation.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= go_conv;
    end
  end

  // Every output is a flop, so the pins never glitch on a decode.
  // The price is one cycle of latency on the enables and the data line,
  // which a host running at a fraction of the block clock never notices.
  assign o_sdo        = sdo_q;
  assign o_sdo_oe_n   = sdo_oe_n_q;
  assign o_sck        = sck_q;
  assign o_sck_oe_n   = sck_oe_n_q;
  assign o_channel    = chan_q;
  assign o_conv_start = start_q;
  assign o_converting = conv_q;
  assign o_int_mode   = int_mode_q;

  // Checks on the behaviour of the port.
  // They all run on the block clock and stay quiet while reset is high.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sdo_release_a: assert property (i_cs_n |=> o_sdo_oe_n)
    else $error("sdo driven while chip select high");

  flag_busy_a: assert property ((st_q == ST_CONV) && !i_cs_n |=> o_sdo)
    else $error("done flag low during conversion");

  flag_ready_a: assert property ((st_q == ST_SLEEP) |=> !o_sdo)
    else $error("done flag high in sleep");

  result_load_a: assert property ((st_q == ST_CONV) ##1 (st_q == ST_SLEEP) |->
      (shift_q == {2'b00, $past(i_sign), $past(i_code)}))
    else $error("result not loaded at end of conversion");

  sdi_ignored_a: assert property ((st_q == ST_CONV) || i_cs_n |=> $stable(addr_sh_q))
    else $error("address shifted while ignored");

  abort_restart_a: assert property ((st_q == ST_DATA) && cs_rise |=>
      (st_q == ST_CONV) && o_conv_start)
    else $error("abort did not restart conversion");

  chan_keep_a: assert property ((st_q == ST_DATA) && cs_rise && (rise_cnt_q < 5'h08) |=>
      $stable(chan_q) [*2])
    else $error("channel changed on early abort");

  conv_length_a: assert property ((st_q == ST_CONV) && !conv_done |=> (st_q == ST_CONV))
    else $error("conversion ended early");

  mode_strap_a: assert property (cs_fall |=> (int_mode_q == $past(i_sck)))
    else $error("clock mode not taken at select fall");

  // After a full word, the flag and the start pulse stand in the first cycle of the new conversion.
  end_restart_a: assert property (
      (st_q == ST_DATA) ##1 (st_q == ST_CONV) && !$past(cs_rise) |-> o_sdo && o_conv_start)
    else $error("full word did not start conversion");

  int_hold_a: assert property (int_mode_q && (st_q == ST_CONV) && !i_cs_n ##1 !i_cs_n
      |-> o_sck && !o_sck_oe_n)
    else $error("internal clock not held high in conversion");

  sck_release_a: assert property (i_cs_n |=> o_sck_oe_n)
    else $error("sck driven while chip select high");

  // One high half period of the divided clock lasts four block cycles.
  sck_half_a: assert property (div_rise && div_run ##1 div_run [*3] |=> div_fall)
    else $error("internal clock half period not four cycles");

  // Between falling edges the output bit must stand, so a host can latch it on the rise.
  data_stand_a: assert property (
      (st_q == ST_DATA) && !sck_fall && !go_conv ##1 !go_conv |=> $stable(o_sdo))
    else $error("sdo changed away from a falling edge");

  // The wake edge is the first of the nineteen rises of a transfer.
  wake_first_a: assert property (
      (st_q == ST_SLEEP) && !i_cs_n && sck_rise |=> (st_q == ST_DATA) && (rise_cnt_q == 5'h01))
    else $error("wake edge not taken as first rise");

  // Covers for the main scenarios of the port.
  full_word_c: cover property ((st_q == ST_DATA) && data_end && !i_cs_n);
  abort_c:     cover property ((st_q == ST_DATA) && cs_rise);
  int_data_c:  cover property (int_mode_q && (st_q == ST_DATA) && div_rise);
  chan_set_c:  cover property (!$stable(chan_q));
  int_end_c:   cover property (int_mode_q && go_conv && !i_cs_n);

endmodule : asp_top

/* tb/asp_host.sv */
// Host controller model: chip select, serial clock and data input of the converter.
module asp_host (
  input  wire logic i_clk,      // Block clock, the host moves on its falling edge.
  input  wire logic i_sdo,      // Serial data output level of the converter.
  input  wire logic i_sdo_oe_n, // Output enable of sdo, low drives.
  input  wire logic i_sck_dev,  // Serial clock level driven by the converter.
  input  wire logic i_sck_oe_n, // Output enable of the converter clock, low drives.
  output logic      o_cs_n,     // Chip select, active low.
  output logic      o_sck,      // Resolved serial clock pin level.
  output logic      o_sdi       // Serial data input level.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic cs_lvl;   // Chip select level we drive.
  logic sck_lvl;  // Serial clock level we drive.
  logic drv_en;   // High while we drive the clock pin.
  logic sdi_lvl;  // Data input level we drive.
  logic sdo_last; // Last level the converter drove on sdo.
  logic sdo_pin;  // Data line as the host sees it.

  initial begin
    cs_lvl   = 1'h1;
    sck_lvl  = 1'h0;
    drv_en   = 1'h1;
    sdi_lvl  = 1'h0;
    sdo_last = 1'h0;
  end

  // A released sdo has no pull, so show the inverse rather than a stale level.
  always @(posedge i_clk) begin
    if (!i_sdo_oe_n) begin
      sdo_last <= i_sdo;
    end
  end

  assign sdo_pin = i_sdo_oe_n ? ~sdo_last : i_sdo;
  // The converter wins when it drives, then the host; a weak pull-up holds the pin when neither drives.
  assign o_sck   = !i_sck_oe_n ? i_sck_dev : (drv_en ? sck_lvl : 1'h1);
  assign o_cs_n  = cs_lvl;
  assign o_sdi   = sdi_lvl;

  // Change chip select, then let it settle for a few cycles.
  task automatic sel(input logic v);
    @(negedge i_clk);
    cs_lvl = v;
    repeat (3) @(negedge i_clk);
  endtask : sel

  // Take the clock pin low and drive it, or release it to the pull-up.
  task automatic hold_sck(input logic en);
    @(negedge i_clk);
    sck_lvl = 1'h0;
    drv_en  = en;
  endtask : hold_sck

  // External clock transfer of n bits, clock held high four block cycles and low six.
  task automatic ext_xfer(input int n, input logic [7:0] addr, output logic [18:0] word);
    word = '0;
    for (int i = 0; i < n; i++) begin
      sdi_lvl = (i < 8) ? addr[7-i] : ~sdi_lvl;
      repeat (2) @(negedge i_clk);
      word    = {word[17:0], sdo_pin};
      sck_lvl = 1'h1;
      repeat (4) @(negedge i_clk);
      sck_lvl = 1'h0;
      repeat (4) @(negedge i_clk);
    end
  endtask : ext_xfer

  // Follow the converter's own clock for 19 rises; data changes only after falls.
  task automatic int_xfer(input logic [7:0] addr, output logic [18:0] word, output int per);
    int   n;
    int   t;
    int   t1;
    logic prev;
    logic sdo_was;
    n       = 0;
    t       = 0;
    t1      = 0;
    per     = 0;
    word    = '0;
    prev    = o_sck;
    sdo_was = sdo_pin;
    sdi_lvl = addr[7];
    while (n < 19 && t < 3000) begin
      @(negedge i_clk);
      t++;
      if (o_sck && !prev) begin
        // Latch what stood before the rise: the converter may raise sdo at
        // the very edge that carries the last bit.
        word = {word[17:0], sdo_was};
        n++;
        if (n == 1) t1 = t;
        if (n == 2) per = t - t1;
      end
      if (!o_sck && prev && n < 8) sdi_lvl = addr[7-n];
      prev = o_sck;
      sdo_was = sdo_pin;
    end
  endtask : int_xfer
endmodule : asp_host

/* tb/testbench.sv */
// Self-checking bench of the converter serial port against a host model.
module testbench
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned CONV_N = 200; // Shortened conversion keeps the run brief.

  logic                  i_clk;        // Block clock.
  logic                  i_rst;        // Synchronous reset.
  logic                  i_sign;       // Result sign for the running conversion.
  logic [CODE_W-1:0]     i_code;       // Result code for the running conversion.
  wire                   cs_n;         // Chip select from the host.
  wire                   sck_pin;      // Resolved serial clock pin.
  wire                   sdi;          // Data input from the host.
  wire                   o_sdo;        // Converter data output.
  wire                   o_sdo_oe_n;   // Its enable.
  wire                   o_sck;        // Converter clock output.
  wire                   o_sck_oe_n;   // Its enable.
  wire [ADDR_BITS-1:0]   o_channel;    // Committed channel.
  wire                   o_conv_start; // Conversion start pulse.
  wire                   o_converting; // Converting level.
  wire                   o_int_mode;   // Internal clock mode.
  int                    err_total;    // Mismatches seen.
  int                    checked;      // Comparisons made.
  int                    starts;       // Start pulses counted.
  int                    chan_m;       // Model of the committed channel.
  logic [18:0]           exp_w;        // Model of the next output word.
  logic [31:0]           rnd;          // Random state.

  asp_top #(.CONV_CYCLES(CONV_N)) asp_top_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck_pin), .i_sdi(sdi),
    .i_sign(i_sign), .i_code(i_code), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
    .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .o_channel(o_channel),
    .o_conv_start(o_conv_start), .o_converting(o_converting), .o_int_mode(o_int_mode));

  asp_host asp_host_i (
    .i_clk(i_clk), .i_sdo(o_sdo), .i_sdo_oe_n(o_sdo_oe_n), .i_sck_dev(o_sck),
    .i_sck_oe_n(o_sck_oe_n), .o_cs_n(cs_n), .o_sck(sck_pin), .o_sdi(sdi));

  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end

  // Count start pulses so each start can be checked as exactly one.
  // Looked at on the falling edge, where the one-cycle pulse stands settled.
  always @(negedge i_clk) begin
    if (o_conv_start === 1'h1) starts <= starts + 1;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // Present a fresh random result; the model word is flag 0, filler 0, sign, code.
  task automatic new_res();
    rnd    = lfsr_next(rnd);
    i_code = rnd[15:0];
    i_sign = rnd[16];
    exp_w  = {1'h0, 1'h0, rnd[16], rnd[15:0]};
  endtask : new_res

  // Wait, bounded, for the conversion to finish.
  task automatic wait_done();
    int t;
    t = 0;
    while (o_converting !== 1'h0 && t < 1000) begin
      @(negedge i_clk);
      t++;
    end
    repeat (3) @(negedge i_clk);
  endtask : wait_done

  task automatic final_report();
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    final_report();
  end

  initial begin
    logic [18:0] w;
    logic [7:0]  a;
    int          per;
    int          s0;
    int          n;
    int          lens[4];
    lens      = '{19, 19, 5, 12};
    err_total = 0;
    checked   = 0;
    starts    = 0;
    chan_m    = 0;
    rnd       = 32'hA6F86D75;
    i_rst     = 1'h1;
    new_res();
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'h0;
    repeat (3) @(negedge i_clk);
    chk("int_mode", 1'h0, o_int_mode);
    chk("sdo_oe_n", 1'h1, o_sdo_oe_n);
    asp_host_i.sel(1'h0);
    chk("busy_flag", 1'h1, o_sdo);
    asp_host_i.ext_xfer(3, 8'hFF, w);
    wait_done();
    chk("done_flag", 1'h0, o_sdo);
    // Two full reads with select held low, then aborts before and after the address.
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr_next(rnd);
      a   = rnd[7:0];
      n   = lens[k];
      s0  = starts;
      asp_host_i.ext_xfer(n, a, w);
      if (n < 19) asp_host_i.sel(1'h1);
      if (n >= 8) chan_m = a;
      if (n == 19) chk("word", exp_w, w);
      if (n == 19) chk("sdo_busy", 1'h1, o_sdo);
      else chk("sdo_oe_n", 1'h1, o_sdo_oe_n);
      chk("channel", chan_m, o_channel);
      chk("starts", s0 + 1, starts);
      chk("converting", 1'h1, o_converting);
      new_res();
      wait_done();
      chk("asleep", 1'h0, o_converting);
      if (n < 19) asp_host_i.sel(1'h0);
      chk("done_flag", 1'h0, o_sdo);
    end
    // Released clock pin straps internal mode; the held result must still come out.
    asp_host_i.sel(1'h1);
    asp_host_i.hold_sck(1'h0);
    asp_host_i.sel(1'h0);
    chk("int_mode", 1'h1, o_int_mode);
    rnd = lfsr_next(rnd);
    a   = rnd[7:0];
    s0  = starts;
    asp_host_i.int_xfer(a, w, per);
    chan_m = a;
    chk("word", exp_w, w);
    chk("sck_period", 8, per);
    repeat (3) @(negedge i_clk);
    chk("channel", chan_m, o_channel);
    chk("sck_held", 1'h1, sck_pin);
    chk("sck_oe_n", 1'h0, o_sck_oe_n);
    chk("sdo_busy", 1'h1, o_sdo);
    chk("starts", s0 + 1, starts);
    asp_host_i.sel(1'h1);
    asp_host_i.hold_sck(1'h1);
    asp_host_i.sel(1'h0);
    chk("int_mode", 1'h0, o_int_mode);
    final_report();
  end
endmodule : testbench
